//--- test/lcsp_host_model.sv
// host master model driving the serial port pins
`timescale 1ns/10ps
module lcsp_host_model (
    input  wire ref_clk,
    input  wire protocolSelect,
    input  wire serialDataOe,
    input  wire serialDataOut,
    output reg  serialClk,
    output reg  spiSelectN,
    output wire serialDataIn
);
    reg hostDrv;
    // i2c: wired-and with pull-up; spi: device wins while it drives
    assign serialDataIn = protocolSelect ? (hostDrv & ~(serialDataOe & ~serialDataOut))
                                         : (serialDataOe ? serialDataOut : hostDrv);
    // clock idles high and stands still outside frames
    initial begin
        serialClk = 1'b1;
        spiSelectN = 1'b1;
        hostDrv = 1'b1;
    end
    task wt(input integer n);
        integer k;
        begin
            for (k = 0; k < n; k = k + 1) @(negedge ref_clk);
        end
    endtask
    task i2cStart;
        begin
            hostDrv = 1'b1;
            wt(5);
            serialClk = 1'b1;
            wt(5);
            hostDrv = 1'b0;
            wt(5);
            serialClk = 1'b0;
        end
    endtask
    task i2cStop;
        begin
            wt(5);
            hostDrv = 1'b0;
            wt(5);
            serialClk = 1'b1;
            wt(5);
            hostDrv = 1'b1;
            wt(10);
        end
    endtask
    // eight bits plus ack slot; data moves only with scl low
    task i2cXfer(input [7:0] w, input a, output [7:0] r, output s);
        integer i;
        reg [8:0] v;
        begin
            v = {w, a};
            for (i = 8; i >= 0; i = i - 1) begin
                wt(5);
                hostDrv = v[i];
                wt(5);
                serialClk = 1'b1;
                wt(10);
                if (i > 0) r[i-1] = serialDataIn;
                else s = serialDataIn;
                serialClk = 1'b0;
            end
        end
    endtask
    task spiByte(input [7:0] w, output [7:0] r);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                serialClk = 1'b0;
                wt(5);
                hostDrv = w[i];
                wt(5);
                r[i] = serialDataIn;
                serialClk = 1'b1;
                wt(10);
            end
        end
    endtask
    task spiSel(input v);
        begin
            wt(5);
            spiSelectN = v;
            wt(10);
        end
    endtask
endmodule

//--- test/lcsp_serial_port_assertions.sv
// concurrent checks on the serial host port pins and word stream
`timescale 1ns/10ps
module lcsp_serial_port_assertions #(
    parameter [7:0] MAX_ADDR = 8'h77
) (
    input wire       ref_clk,
    input wire       sys_rst,
    input wire       protocolSelect,
    input wire       serialClk,
    input wire       spiSelectN,
    input wire       serialDataOut,
    input wire       serialDataOe,
    input wire       outValid,
    input wire       outReady,
    input wire [1:0] outKind,
    input wire [7:0] outAddr,
    input wire [7:0] outData,
    input wire [7:0] ramRdAddr
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // i2c drive may only move while the clock is low
    AST_I2C_OE_SCL_LOW: assert property (
        protocolSelect && $changed(serialDataOe) |-> !serialClk)
        else $error("i2c data drive changed with clock high");
    AST_I2C_OPEN_DRAIN: assert property (
        protocolSelect && serialDataOe |-> !serialDataOut)
        else $error("i2c pin driven high");
    // select high must release the data pin after sync latency
    AST_SPI_IDLE_RELEASE: assert property (
        (!protocolSelect && spiSelectN) [*5] |-> !serialDataOe)
        else $error("spi pin driven while deselected");
    AST_SPI_OUT_ON_FALL: assert property (
        !protocolSelect && serialDataOe && $past(serialDataOe)
        && $changed(serialDataOut) |-> !serialClk)
        else $error("spi output bit moved with clock high");
    // a stalled word holds still until taken
    AST_WORD_HOLD: assert property (
        outValid && !outReady |=> outValid && $stable(outData)
        && $stable(outKind) && $stable(outAddr))
        else $error("word changed while stalled");
    AST_ADDR_ONLY_RAM: assert property (
        outValid && outKind != 2'h2 |-> outAddr == 8'h00)
        else $error("address on non ram word");
    AST_RAM_ADDR_LIMIT: assert property (
        outValid && outKind == 2'h2 |-> outAddr <= MAX_ADDR)
        else $error("ram word beyond limit");
    AST_PTR_RANGE: assert property (ramRdAddr <= MAX_ADDR)
        else $error("pointer beyond limit");

    // main scenarios reached
    cover property (outValid && outReady && outKind == 2'h2);
    cover property (protocolSelect && serialDataOe);
    cover property (!protocolSelect && serialDataOe);
endmodule

bind lcsp_serial_port lcsp_serial_port_assertions #(.MAX_ADDR(MAX_ADDR))
    lcsp_serial_port_assertions_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .protocolSelect(protocolSelect),
    .serialClk(serialClk), .spiSelectN(spiSelectN), .serialDataOut(serialDataOut),
    .serialDataOe(serialDataOe), .outValid(outValid), .outReady(outReady), .outKind(outKind),
    .outAddr(outAddr), .outData(outData), .ramRdAddr(ramRdAddr));

//--- test/lcsp_serial_port_bench.sv
// self-checking bench of the serial host port
`timescale 1ns/10ps
module lcsp_serial_port_bench;
    reg         ref_clk;
    reg         sys_rst;
    reg         protocolSelect;
    reg         outReady;
    reg         stall;
    wire        serialClk;
    wire        spiSelectN;
    wire        serialDataIn;
    wire        serialDataOut;
    wire        serialDataOe;
    wire        outValid;
    wire [1:0]  outKind;
    wire [7:0]  outAddr;
    wire [7:0]  outData;
    wire [7:0]  ramRdAddr;
    wire [7:0]  ramRdData;
    integer     n_mismatch;
    integer     cmp_count;
    reg  [17:0] got[$];
    reg  [7:0]  rd;
    reg         ack;

    lcsp_serial_port lcsp_serial_port_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .protocolSelect(protocolSelect), .serialClk(serialClk), .spiSelectN(spiSelectN),
        .serialDataIn(serialDataIn), .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
        .outValid(outValid), .outReady(outReady), .outKind(outKind), .outAddr(outAddr),
        .outData(outData), .ramRdAddr(ramRdAddr), .ramRdData(ramRdData));
    lcsp_host_model lcsp_host_model_i (.ref_clk(ref_clk), .protocolSelect(protocolSelect),
        .serialDataOe(serialDataOe), .serialDataOut(serialDataOut), .serialClk(serialClk),
        .spiSelectN(spiSelectN), .serialDataIn(serialDataIn));

    // ram content is a known function of the pointer
    assign ramRdData = ramRdAddr ^ 8'h5A;
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // capture taken words; display commands are consumed internally
    always @(posedge ref_clk)
        if (outValid === 1'b1 && outReady && !(outKind == 2'h0 && outData[7:1] == 7'h40))
            got.push_back({outKind, outAddr, outData});
    always @(negedge ref_clk) outReady <= ~stall;

    task check(input ok, input [8*20-1:0] msg);
        begin
            cmp_count = cmp_count + 1;
            if (!ok) begin
                n_mismatch = n_mismatch + 1;
                $display("mismatch at %0t: %0s", $time, msg);
            end
        end
    endtask
    task expWord(input [17:0] w);
        integer k;
        begin
            for (k = 0; k < 400 && got.size() == 0; k = k + 1) @(negedge ref_clk);
            if (got.size() == 0) check(1'b0, "word missing");
            else check(got.pop_front() === w, "word value");
        end
    endtask
    task ib(input [7:0] w, input e);
        begin
            lcsp_host_model_i.i2cXfer(w, 1'b1, rd, ack);
            check(ack === e, "i2c ack");
        end
    endtask
    // page write with stalled core and pointer wrap
    task t_page;
        begin
            stall = 1'b1;
            lcsp_host_model_i.i2cStart;
            ib(8'h78, 1'b0);
            ib(8'h80, 1'b0);
            ib(8'h76, 1'b0);
            ib(8'hA1, 1'b0);
            ib(8'hB2, 1'b0);
            ib(8'hC3, 1'b0);
            stall = 1'b0;
            lcsp_host_model_i.i2cStop;
            expWord({2'h2, 8'h76, 8'hA1});
            expWord({2'h2, 8'h77, 8'hB2});
            expWord({2'h2, 8'h00, 8'hC3});
            check(ramRdAddr === 8'h01, "pointer after page");
            $display("test page done");
        end
    endtask
    task t_nomatch;
        begin
            lcsp_host_model_i.i2cStart;
            ib(8'h7A, 1'b1);
            ib(8'h88, 1'b1);
            lcsp_host_model_i.i2cStop;
            check(got.size() == 0, "foreign traffic");
            $display("test nomatch done");
        end
    endtask
    // command with parameter, then out-of-range ram address
    task t_cmd_limit;
        begin
            lcsp_host_model_i.i2cStart;
            ib(8'h78, 1'b0);
            ib(8'h88, 1'b0);
            ib(8'h0A, 1'b0);
            lcsp_host_model_i.i2cStop;
            expWord({2'h0, 8'h00, 8'h88});
            expWord({2'h1, 8'h00, 8'h0A});
            lcsp_host_model_i.i2cStart;
            ib(8'h78, 1'b0);
            ib(8'h80, 1'b0);
            ib(8'h78, 1'b0);
            ib(8'h55, 1'b0);
            lcsp_host_model_i.i2cStop;
            lcsp_host_model_i.wt(50);
            check(got.size() == 0 && ramRdAddr === 8'h01, "limit discard");
            $display("test cmd_limit done");
        end
    endtask
    task t_read;
        begin
            lcsp_host_model_i.i2cStart;
            ib(8'h78, 1'b0);
            ib(8'h81, 1'b0);
            ib(8'h10, 1'b0);
            lcsp_host_model_i.i2cStart;
            ib(8'h79, 1'b0);
            lcsp_host_model_i.i2cXfer(8'hFF, 1'b0, rd, ack);
            check(rd === 8'h4A, "i2c read byte 0");
            lcsp_host_model_i.i2cXfer(8'hFF, 1'b1, rd, ack);
            check(rd === 8'h4B, "i2c read byte 1");
            lcsp_host_model_i.i2cStop;
            check(ramRdAddr === 8'h11 && serialDataOe === 1'b0, "read end");
            $display("test read done");
        end
    endtask
    // spi page write with wrap, then command held at clock high
    task t_spi_write;
        begin
            protocolSelect = 1'b0;
            lcsp_host_model_i.spiSel(1'b0);
            lcsp_host_model_i.spiByte(8'h80, rd);
            lcsp_host_model_i.spiByte(8'h77, rd);
            lcsp_host_model_i.spiByte(8'h11, rd);
            lcsp_host_model_i.spiByte(8'h22, rd);
            lcsp_host_model_i.spiSel(1'b1);
            expWord({2'h2, 8'h77, 8'h11});
            expWord({2'h2, 8'h00, 8'h22});
            check(ramRdAddr === 8'h01, "spi pointer");
            lcsp_host_model_i.spiSel(1'b0);
            lcsp_host_model_i.spiByte(8'h88, rd);
            lcsp_host_model_i.wt(20);
            lcsp_host_model_i.spiByte(8'h0A, rd);
            lcsp_host_model_i.spiSel(1'b1);
            expWord({2'h0, 8'h00, 8'h88});
            expWord({2'h1, 8'h00, 8'h0A});
            $display("test spi_write done");
        end
    endtask
    task t_spi_read;
        begin
            // i2c framing must be ignored while spi is strapped
            lcsp_host_model_i.i2cStart;
            ib(8'h78, 1'b1);
            lcsp_host_model_i.i2cStop;
            lcsp_host_model_i.spiSel(1'b0);
            lcsp_host_model_i.spiByte(8'h81, rd);
            lcsp_host_model_i.spiByte(8'h40, rd);
            lcsp_host_model_i.spiSel(1'b1);
            lcsp_host_model_i.spiSel(1'b0);
            lcsp_host_model_i.spiByte(8'h55, rd);
            check(rd === 8'h1A, "spi read byte 0");
            lcsp_host_model_i.spiByte(8'h55, rd);
            check(rd === 8'h1B, "spi read byte 1");
            lcsp_host_model_i.spiSel(1'b1);
            check(ramRdAddr === 8'h42 && serialDataOe === 1'b0, "spi read end");
            $display("test spi_read done");
        end
    endtask
    task report_and_stop;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
            if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    // main sequence
    initial begin
        sys_rst = 1'b1;
        protocolSelect = 1'b1;
        stall = 1'b0;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (6) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (5) @(negedge ref_clk);
        check(serialDataOe === 1'b0 && ramRdAddr === 8'h00, "reset state");
        t_page;
        t_nomatch;
        t_cmd_limit;
        t_read;
        t_spi_write;
        t_spi_read;
        report_and_stop;
    end
    // watchdog well beyond the expected run of some 6000 cycles
    initial begin
        #400000;
        n_mismatch = n_mismatch + 1;
        report_and_stop;
    end
endmodule

//--- verilog/lcsp_defs.vh
// shared constants of the lcd serial host port
`ifndef LCSP_DEFS_VH
`define LCSP_DEFS_VH

`define LCSP_I2C_ADDR        7'h3C
`define LCSP_WRITE_DISP_CMD  8'h80
`define LCSP_READ_DISP_CMD   8'h81
`define LCSP_MAX_ADDR        8'h77
`define LCSP_KIND_CMD        2'h0
`define LCSP_KIND_PARAM      2'h1
`define LCSP_KIND_RAMWR      2'h2
`define LCSP_LAST_BIT        4'h7
`define LCSP_ACK_BIT         4'h8
`define LCSP_ACK_DONE        4'h9
`define LCSP_IDX_CMD         2'h0
`define LCSP_IDX_ADDR        2'h1
`define LCSP_IDX_DATA        2'h2
`define LCSP_WORD_W          18

`endif

//--- verilog/lcsp_serial_port.v
// serial host port (i2c slave or 3-wire spi slave) of an lcd driver
// Summary of operation
// - i2c data sampled only on clock high
// - sda falls while scl high: start
// - sda rises while scl high: stop
// - repeated start restarts address reception
// - i2c bytes eight bits, msb first, ack
// - device pulls sda low on ninth clock
// - address 0111100 plus direction bit acknowledged
// - parameter bytes follow command, routed onward
// - ram address beyond limit discards data
// - i2c pointer advances after ack clock
// - pointer wraps to zero past maximum
// - i2c read: set address, restart, stream
// - select high resets spi, fall starts
// - spi samples data on rising clock, msb first
// - every eight spi bits form one byte
// - select pulse turns pin to output
// - spi read data driven on falling clock
// - spi page write advances pointer per byte
// - spi read streams until select rises
`timescale 1ns/10ps
`include "lcsp_defs.vh"
module lcsp_serial_port #(
    parameter [7:0] WRITE_DISP_CMD = `LCSP_WRITE_DISP_CMD,
    parameter [7:0] READ_DISP_CMD  = `LCSP_READ_DISP_CMD,
    parameter [7:0] MAX_ADDR       = `LCSP_MAX_ADDR
) (
    input  wire       ref_clk,
    input  wire       sys_rst,
    input  wire       protocolSelect,
    input  wire       serialClk,
    input  wire       spiSelectN,
    input  wire       serialDataIn,
    output reg        serialDataOut,
    output reg        serialDataOe,
    output wire       outValid,
    input  wire       outReady,
    output wire [1:0] outKind,
    output wire [7:0] outAddr,
    output wire [7:0] outData,
    output reg  [7:0] ramRdAddr,
    input  wire [7:0] ramRdData
);
    localparam [2:0] ST_IDLE   = 3'h0;
    localparam [2:0] ST_ADDR   = 3'h1;
    localparam [2:0] ST_WRITE  = 3'h2;
    localparam [2:0] ST_READ   = 3'h3;
    localparam [2:0] ST_IGNORE = 3'h4;

    // two-stage synchronisers plus one history stage for edges
    reg                    selMeta;
    reg                    selSync;
    reg                    clkMeta;
    reg                    clkSync;
    reg                    clkPrev;
    reg                    dataMeta;
    reg                    dataSync;
    reg                    dataPrev;
    reg                    csMeta;
    reg                    csSync;
    reg                    csPrev;
    reg  [2:0]             i2cState;
    reg  [3:0]             bitCnt;
    reg  [7:0]             rxShift;
    reg  [7:0]             txShift;
    reg  [1:0]             byteIdx;
    reg  [7:0]             cmdReg;
    reg                    addrBad;
    reg                    ackOk;
    reg                    dirRead;
    reg                    masterAck;
    reg                    incPend;
    reg                    loadPend;
    reg                    spiArmed;
    reg                    spiOut;
    reg                    pushValid;
    reg  [`LCSP_WORD_W-1:0] pushWord;
    wire                   pushReady;
    wire                   clkRise;
    wire                   clkFall;
    wire                   i2cStart;
    wire                   i2cStop;
    wire                   csRise;
    wire                   csFall;
    wire [7:0]             rxByte;

    // wrap-around increment of the display ram pointer
    function [7:0] nextPtr;
        input [7:0] p;
        begin
            nextPtr = (p >= MAX_ADDR) ? 8'h00 : p + 8'h01;
        end
    endfunction

    assign clkRise  = clkSync & ~clkPrev;
    assign clkFall  = ~clkSync & clkPrev;
    // start/stop need scl high on both samples so our own ack never looks like one
    assign i2cStart = clkSync & clkPrev & dataPrev & ~dataSync;
    assign i2cStop  = clkSync & clkPrev & ~dataPrev & dataSync;
    assign csRise   = csSync & ~csPrev;
    assign csFall   = ~csSync & csPrev;
    assign rxByte   = {rxShift[6:0], dataSync};

    // pin synchronisers; bus idles high
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            selMeta  <= 1'b1;
            selSync  <= 1'b1;
            clkMeta  <= 1'b1;
            clkSync  <= 1'b1;
            clkPrev  <= 1'b1;
            dataMeta <= 1'b1;
            dataSync <= 1'b1;
            dataPrev <= 1'b1;
            csMeta   <= 1'b1;
            csSync   <= 1'b1;
            csPrev   <= 1'b1;
        end else begin
            selMeta  <= protocolSelect;
            selSync  <= selMeta;
            clkMeta  <= serialClk;
            clkSync  <= clkMeta;
            clkPrev  <= clkSync;
            dataMeta <= serialDataIn;
            dataSync <= dataMeta;
            dataPrev <= dataSync;
            csMeta   <= spiSelectN;
            csSync   <= csMeta;
            csPrev   <= csSync;
        end
    end

    // common byte decoder: command, parameters, ram address and data
    task handleByte;
        input [7:0] b;
        begin
            if (byteIdx == `LCSP_IDX_CMD) begin
                cmdReg  <= b;
                byteIdx <= `LCSP_IDX_ADDR;
                if (b != WRITE_DISP_CMD && b != READ_DISP_CMD) begin
                    pushValid <= 1'b1;
                    pushWord  <= {`LCSP_KIND_CMD, 8'h00, b};
                end
            end else if (cmdReg == WRITE_DISP_CMD || cmdReg == READ_DISP_CMD) begin
                if (byteIdx == `LCSP_IDX_ADDR) begin
                    byteIdx <= `LCSP_IDX_DATA;
                    addrBad <= (b > MAX_ADDR);
                    if (b <= MAX_ADDR) begin
                        ramRdAddr <= b;
                    end
                    spiArmed <= (cmdReg == READ_DISP_CMD) & ~selSync;
                end else if (cmdReg == WRITE_DISP_CMD && !addrBad) begin
                    pushValid <= 1'b1;
                    pushWord  <= {`LCSP_KIND_RAMWR, ramRdAddr, b};
                    // spi advances at once, i2c waits for the ack clock
                    if (selSync) begin
                        incPend <= 1'b1;
                    end else begin
                        ramRdAddr <= nextPtr(ramRdAddr);
                    end
                end
            end else begin
                byteIdx   <= `LCSP_IDX_DATA;
                pushValid <= 1'b1;
                pushWord  <= {`LCSP_KIND_PARAM, 8'h00, b};
            end
        end
    endtask

    // protocol engines; only the strapped protocol sees edges
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            i2cState      <= ST_IDLE;
            bitCnt        <= 4'h0;
            rxShift       <= 8'h00;
            txShift       <= 8'h00;
            byteIdx       <= `LCSP_IDX_CMD;
            cmdReg        <= 8'h00;
            addrBad       <= 1'b0;
            ackOk         <= 1'b0;
            dirRead       <= 1'b0;
            masterAck     <= 1'b0;
            incPend       <= 1'b0;
            loadPend      <= 1'b0;
            spiArmed      <= 1'b0;
            spiOut        <= 1'b0;
            pushValid     <= 1'b0;
            pushWord      <= {`LCSP_WORD_W{1'b0}};
            ramRdAddr     <= 8'h00;
            serialDataOut <= 1'b0;
            serialDataOe  <= 1'b0;
        end else begin
            if (pushValid && pushReady) begin
                pushValid <= 1'b0;
            end
            // ram answers combinationally to ramRdAddr, fetched a cycle later
            if (loadPend) begin
                loadPend <= 1'b0;
                txShift  <= ramRdData;
                if (selSync) begin
                    serialDataOe <= ~ramRdData[7];
                end
            end
            if (selSync) begin
                serialDataOut <= 1'b0;
                if (i2cStart) begin
                    i2cState     <= ST_ADDR;
                    bitCnt       <= 4'h0;
                    byteIdx      <= `LCSP_IDX_CMD;
                    incPend      <= 1'b0;
                    serialDataOe <= 1'b0;
                end else if (i2cStop) begin
                    i2cState     <= ST_IDLE;
                    serialDataOe <= 1'b0;
                end else if (i2cState != ST_IDLE && i2cState != ST_IGNORE) begin
                    if (clkRise) begin
                        if (bitCnt < `LCSP_ACK_BIT) begin
                            rxShift <= rxByte;
                            bitCnt  <= bitCnt + 4'h1;
                            if (bitCnt == `LCSP_LAST_BIT) begin
                                case (i2cState)
                                    ST_ADDR: begin
                                        ackOk   <= (rxByte[7:1] == `LCSP_I2C_ADDR);
                                        dirRead <= rxByte[0];
                                    end
                                    ST_WRITE: begin
                                        handleByte(rxByte);
                                    end
                                    default: begin
                                    end
                                endcase
                            end
                        end else if (bitCnt == `LCSP_ACK_BIT) begin
                            bitCnt    <= `LCSP_ACK_DONE;
                            masterAck <= ~dataSync;
                        end
                    end else if (clkFall) begin
                        if (bitCnt == `LCSP_ACK_BIT) begin
                            // pull low for the whole ninth clock, or release for master
                            serialDataOe <= (i2cState == ST_WRITE) ||
                                            (i2cState == ST_ADDR && ackOk);
                        end else if (bitCnt == `LCSP_ACK_DONE) begin
                            serialDataOe <= 1'b0;
                            bitCnt       <= 4'h0;
                            case (i2cState)
                                ST_ADDR: begin
                                    if (!ackOk) begin
                                        i2cState <= ST_IGNORE;
                                    end else if (dirRead) begin
                                        i2cState <= ST_READ;
                                        loadPend <= 1'b1;
                                    end else begin
                                        i2cState <= ST_WRITE;
                                    end
                                end
                                ST_WRITE: begin
                                    if (incPend) begin
                                        incPend   <= 1'b0;
                                        ramRdAddr <= nextPtr(ramRdAddr);
                                    end
                                end
                                ST_READ: begin
                                    if (masterAck) begin
                                        ramRdAddr <= nextPtr(ramRdAddr);
                                        loadPend  <= 1'b1;
                                    end else begin
                                        i2cState <= ST_IGNORE;
                                    end
                                end
                                default: begin
                                end
                            endcase
                        end else if (i2cState == ST_READ && bitCnt != 4'h0) begin
                            serialDataOe <= ~txShift[6];
                            txShift      <= {txShift[6:0], 1'b0};
                        end
                    end
                end
            end else if (csSync) begin
                // select high: spi engine held in reset
                bitCnt       <= 4'h0;
                byteIdx      <= `LCSP_IDX_CMD;
                serialDataOe <= 1'b0;
                if (csRise) begin
                    spiOut   <= spiArmed & ~spiOut;
                    spiArmed <= 1'b0;
                end
            end else begin
                if (csFall && spiOut) begin
                    loadPend <= 1'b1;
                end
                if (clkRise && !spiOut) begin
                    rxShift <= rxByte;
                    if (bitCnt == `LCSP_LAST_BIT) begin
                        bitCnt <= 4'h0;
                        handleByte(rxByte);
                    end else begin
                        bitCnt <= bitCnt + 4'h1;
                    end
                end else if (clkFall && spiOut) begin
                    serialDataOut <= txShift[7];
                    serialDataOe  <= 1'b1;
                    txShift       <= {txShift[6:0], 1'b0};
                    if (bitCnt == `LCSP_LAST_BIT) begin
                        bitCnt    <= 4'h0;
                        ramRdAddr <= nextPtr(ramRdAddr);
                        loadPend  <= 1'b1;
                    end else begin
                        bitCnt <= bitCnt + 4'h1;
                    end
                end
            end
        end
    end

    // decoded words wait here while the core stalls
    lcsp_skid_buffer #(
        .WIDTH(`LCSP_WORD_W)
    ) u_buffer (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .inData   (pushWord),
        .outValid (outValid),
        .outReady (outReady),
        .outData  ({outKind, outAddr, outData})
    );
endmodule

//--- verilog/lcsp_skid_buffer.v
// two-entry valid/ready buffer between byte decoder and core
`timescale 1ns/10ps
module lcsp_skid_buffer #(
    parameter WIDTH = 18
) (
    input  wire             ref_clk,
    input  wire             sys_rst,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output reg              outValid,
    input  wire             outReady,
    output reg  [WIDTH-1:0] outData
);
    reg             spareValid;
    reg [WIDTH-1:0] spareData;
    wire            push;
    wire            pop;

    // ready only while the spare slot is empty, so no word is ever dropped
    assign inReady = ~spareValid;
    assign push    = inValid & ~spareValid;
    assign pop     = outValid & outReady;

    // head slot feeds the port directly, spare slot absorbs a stall
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            outValid   <= 1'b0;
            outData    <= {WIDTH{1'b0}};
            spareValid <= 1'b0;
            spareData  <= {WIDTH{1'b0}};
        end else if (pop && spareValid) begin
            outData    <= spareData;
            spareValid <= 1'b0;
        end else if (pop) begin
            outValid <= push;
            if (push) begin
                outData <= inData;
            end
        end else if (push) begin
            if (!outValid) begin
                outValid <= 1'b1;
                outData  <= inData;
            end else begin
                spareValid <= 1'b1;
                spareData  <= inData;
            end
        end
    end
endmodule
